// File: design/gpcfg_top.sv
// gpcfg_top: APB slave giving indirect access to the configuration of four I/O ports
//
// Function
// - every port has an eight-bit read/write select register that picks the sub-register behind its control register.
// - a control register access touches only the sub-register picked by that port's select value.
// - select values zero and nine upward pick nothing, so control accesses then change no configuration.
// - select values one to eight pick direction, alt enable, open drain, high drive, stop wake, pull-up, set one, set two.
// - the select register resets to zero so nothing is reachable until software picks a sub-register.
// - the second alternate set holds one read/write bit per pin that helps choose the pin's alternate function.
// - the second alternate set resets to zero, except four on the first port of the eight-pin variant.
// - a pin takes its chosen alternate function only while its alternate enable bit is also set.
// - the first alternate set holds one bit per pin that together with the set two bit picks the function.
//
// Added by the designer: the APB register port.
module gpcfg_top
   import gpcfg_pkg::*;
#(
   parameter bit EIGHT_PIN_VARIANT = 1'b0
) (
   input  wire logic                      MCLK_IN,
   input  wire logic                      RESET_N_IN,
   input  wire logic                      PSEL_IN,
   input  wire logic                      PENABLE_IN,
   input  wire logic                      PWRITE_IN,
   input  wire logic [ADDR_W-1:0]         PADDR_IN,
   input  wire logic [31:0]               PWDATA_IN,
   input  wire logic [3:0]                PSTRB_IN,
   output logic      [31:0]               PRDATA_OUT,
   output logic                           PREADY_OUT,
   output logic                           PSLVERR_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_DIR_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_ALT_EN_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_OPEN_DRAIN_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_HIGH_DRIVE_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_STOP_WAKE_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_PULLUP_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_ALT_FUNCTION_SET_ONE_BITS_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PORT_ALT_FUNCTION_SET_TWO_BITS_OUT,
   output logic      [NUM_PORTS*PINS-1:0] PIN_ALT_ACTIVE_OUT,
   output logic      [2*NUM_PORTS*PINS-1:0] PIN_ALT_CODE_OUT
);

   // ==========================================================
   // bus phase decode
   gpcfg_dec_type     dec;
   logic              setup;
   logic              access_wr;
   logic [NUM_PORTS-1:0] sel_wr;
   logic [NUM_PORTS-1:0] ctl_wr;
   logic [7:0]        port_sel   [NUM_PORTS];
   logic [7:0]        port_rdata [NUM_PORTS];
   logic [SUBS_W-1:0] port_subs  [NUM_PORTS];
   logic [31:0]       prdata_q;
   logic [31:0]       prdata_d;
   logic              slverr_q;
   logic              slverr_d;

   // the address decode is shared by the setup capture and the write strobe
   assign dec       = gpcfg_decode(PADDR_IN);
   assign setup     = PSEL_IN && !PENABLE_IN;
   // only the low byte lane carries register data, so it gates every write
   assign access_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0] && dec.hit;

   // per-port strobes, one cycle wide at the completing access edge
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         sel_wr[p] = access_wr && !dec.is_ctl && (dec.port == 2'(p));
         ctl_wr[p] = access_wr &&  dec.is_ctl && (dec.port == 2'(p));
      end
   end

   // ==========================================================
   // port banks
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      // the eight-pin part only has the first port with a non-zero set two reset
      localparam logic [7:0] AFS2_RST = (EIGHT_PIN_VARIANT && (p == 0)) ? AFS2_RESET_8PIN : AFS2_RESET;

      gpcfg_port #(
         .AFS2_RST       (AFS2_RST)
      ) u_port (
         .clk_in         (MCLK_IN),
         .rst_n_in       (RESET_N_IN),
         .sel_wr_in      (sel_wr[p]),
         .ctl_wr_in      (ctl_wr[p]),
         .wdata_in       (PWDATA_IN[7:0]),
         .sel_out        (port_sel[p]),
         .ctl_rdata_out  (port_rdata[p]),
         .subs_out       (port_subs[p]),
         .alt_active_out (PIN_ALT_ACTIVE_OUT[p*PINS +: PINS]),
         .alt_code_out   (PIN_ALT_CODE_OUT[2*p*PINS +: 2*PINS])
      );

      // configuration buses straight from the bank flops
      assign PORT_DIR_OUT[p*PINS +: PINS]        = port_subs[p][SUB_DIR*PINS +: PINS];
      assign PORT_ALT_EN_OUT[p*PINS +: PINS]     = port_subs[p][SUB_AFEN*PINS +: PINS];
      assign PORT_OPEN_DRAIN_OUT[p*PINS +: PINS] = port_subs[p][SUB_OD*PINS +: PINS];
      assign PORT_HIGH_DRIVE_OUT[p*PINS +: PINS] = port_subs[p][SUB_HDRV*PINS +: PINS];
      assign PORT_STOP_WAKE_OUT[p*PINS +: PINS]  = port_subs[p][SUB_SWAKE*PINS +: PINS];
      assign PORT_PULLUP_OUT[p*PINS +: PINS]     = port_subs[p][SUB_PULL*PINS +: PINS];
      assign PORT_ALT_FUNCTION_SET_ONE_BITS_OUT[p*PINS +: PINS] = port_subs[p][SUB_AFS1*PINS +: PINS];
      assign PORT_ALT_FUNCTION_SET_TWO_BITS_OUT[p*PINS +: PINS] = port_subs[p][SUB_AFS2*PINS +: PINS];
   end

   // ==========================================================
   // read data and error are captured in the setup phase
   // reads have no side effects, so sampling one cycle early is safe
   always_comb begin
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (setup) begin
         slverr_d = !dec.hit;
         prdata_d = RDATA_RESET;
         if (dec.hit && !PWRITE_IN) begin
            if (dec.is_ctl) begin
               prdata_d[7:0] = port_rdata[dec.port];
            end else begin
               prdata_d[7:0] = port_sel[dec.port];
            end
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         prdata_q <= RDATA_RESET;
         slverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // zero wait states: every access phase completes at its first edge
   assign PREADY_OUT  = 1'b1;
   assign PRDATA_OUT  = prdata_q;
   assign PSLVERR_OUT = slverr_q && PSEL_IN && PENABLE_IN;

   // ==========================================================
   // checks
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
      localparam logic [7:0] EXP_AFS2 = (EIGHT_PIN_VARIANT && (p == 0)) ? AFS2_RESET_8PIN : AFS2_RESET;

      // select register follows a write to it
      chk_sel_write_taken: assert property (
         sel_wr[p] |=> (port_sel[p] == $past(PWDATA_IN[7:0])))
         else $error("select register did not take the written value");

      // after reset release nothing is selected
      chk_sel_reset_zero: assert property (
         $rose(RESET_N_IN) |-> (port_sel[p] == SEL_RESET))
         else $error("select register not zero after reset");

      // set two reset value per port
      chk_afs2_reset_value: assert property (
         $rose(RESET_N_IN) |-> (port_subs[p][SUB_AFS2*PINS +: PINS] == EXP_AFS2))
         else $error("set two reset value wrong");

      // a valid control write lands in the selected lane
      chk_ctl_write_lane: assert property (
         (ctl_wr[p] && gpcfg_sel_valid(port_sel[p])) |=>
            (gpcfg_pick(port_subs[p], $past(port_sel[p])) == $past(PWDATA_IN[7:0])))
         else $error("control write missed the selected sub-register");

      // no other lane of the bank moves on a control write
      chk_ctl_other_lanes: assert property (
         ctl_wr[p] |=> (((port_subs[p] ^ $past(port_subs[p])) &
                         ~gpcfg_lane_mask($past(port_sel[p]))) == '0))
         else $error("control write disturbed an unselected sub-register");

      // with nothing selected the bank holds for the write and the next cycle
      chk_ctl_guard_hold: assert property (
         (ctl_wr[p] && !gpcfg_sel_valid(port_sel[p])) |=> $stable(port_subs[p]) [*2])
         else $error("control write changed a port with nothing selected");

      // a bank never moves without a control write to it
      chk_bank_quiet: assert property (
         !ctl_wr[p] |=> $stable(port_subs[p]))
         else $error("sub-register changed without a control write");

      // pin alternate code gated by the enable lane
      chk_alt_gate: assert property (
         (PIN_ALT_ACTIVE_OUT[p*PINS +: PINS] == port_subs[p][SUB_AFEN*PINS +: PINS]) &&
         ((PIN_ALT_CODE_OUT[2*p*PINS +: 2*PINS] != '0) ->
            (port_subs[p][SUB_AFEN*PINS +: PINS] != '0)))
         else $error("alternate code active without its enable");

      // pin zero's code carries set two high and set one low while that pin is enabled
      chk_alt_code_bits: assert property (
         (port_subs[p][SUB_AFEN*PINS] == 1'b1) |->
            (PIN_ALT_CODE_OUT[2*p*PINS +: 2] ==
             {port_subs[p][SUB_AFS2*PINS], port_subs[p][SUB_AFS1*PINS]}))
         else $error("alternate code does not match set bits");

      // main scenarios
      cov_afs2_written: cover property (
         sel_wr[p] && (PWDATA_IN[7:0] == SEL_AFS2) ##[1:20] ctl_wr[p]);
   end

   // control reads with nothing selected return zero in the access phase
   chk_read_guard_zero: assert property (
      (setup && dec.hit && dec.is_ctl && !PWRITE_IN && !gpcfg_sel_valid(port_sel[dec.port]))
         |=> (PRDATA_OUT == RDATA_RESET))
      else $error("control read with nothing selected returned non-zero");

   // control reads return the selected sub-register
   chk_read_selected: assert property (
      (setup && dec.hit && dec.is_ctl && !PWRITE_IN)
         |=> (PRDATA_OUT[7:0] == gpcfg_pick(port_subs[$past(dec.port)], port_sel[$past(dec.port)])))
      else $error("control read returned the wrong sub-register");

   // unmapped addresses answer with an error and change nothing
   chk_unmapped_error: assert property (
      (setup && !dec.hit) ##1 (PSEL_IN && PENABLE_IN) |-> PSLVERR_OUT)
      else $error("unmapped access did not raise the error");

   cov_guard_read: cover property (
      setup && dec.hit && dec.is_ctl && !PWRITE_IN && (port_sel[dec.port] == SEL_NONE));

   cov_unmapped: cover property (PSLVERR_OUT);

   cov_alt_active: cover property (PIN_ALT_ACTIVE_OUT != '0 && PIN_ALT_CODE_OUT != '0);

endmodule

// File: shared/gpcfg_pkg.sv
// gpcfg_pkg: shared constants, decode and lane helpers for the port configuration block
package gpcfg_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_PORTS = 4;
   localparam int PINS      = 8;
   localparam int SUB_COUNT = 8;
   localparam int ADDR_W    = 14;
   localparam int SUBS_W    = SUB_COUNT * PINS;

   // ==========================================================
   // register indexes (byte address is four times the index)
   localparam logic [11:0] ADDR_REG_IDX_BASE = 12'hfd0;
   localparam logic [11:0] CTL_REG_IDX_BASE  = 12'hfd1;
   localparam logic [11:0] PORT_STRIDE       = 12'h004;
   localparam logic [11:0] MAP_SPAN          = 12'h010;
   localparam logic [1:0]  KIND_ADDR         = 2'h0;
   localparam logic [1:0]  KIND_CTL          = 2'(CTL_REG_IDX_BASE - ADDR_REG_IDX_BASE);
   localparam logic [1:0]  WORD_ALIGNED      = 2'h0;

   // ==========================================================
   // sub-register select codes
   localparam logic [7:0] SEL_NONE  = 8'h00;
   localparam logic [7:0] SEL_DIR   = 8'h01;
   localparam logic [7:0] SEL_AFEN  = 8'h02;
   localparam logic [7:0] SEL_OD    = 8'h03;
   localparam logic [7:0] SEL_HDRV  = 8'h04;
   localparam logic [7:0] SEL_SWAKE = 8'h05;
   localparam logic [7:0] SEL_PULL  = 8'h06;
   localparam logic [7:0] SEL_AFS1  = 8'h07;
   localparam logic [7:0] SEL_AFS2  = 8'h08;
   localparam logic [7:0] SEL_FIRST = SEL_DIR;
   localparam logic [7:0] SEL_LAST  = SEL_AFS2;

   // lane of each sub-register inside the flat sub vector (code minus one)
   localparam int SUB_DIR   = 0;
   localparam int SUB_AFEN  = 1;
   localparam int SUB_OD    = 2;
   localparam int SUB_HDRV  = 3;
   localparam int SUB_SWAKE = 4;
   localparam int SUB_PULL  = 5;
   localparam int SUB_AFS1  = 6;
   localparam int SUB_AFS2  = 7;

   // ==========================================================
   // reset values
   localparam logic [7:0]  SEL_RESET       = SEL_NONE;
   localparam logic [7:0]  SUB_RESET       = 8'h00;
   localparam logic [7:0]  AFS2_RESET      = 8'h00;
   localparam logic [7:0]  AFS2_RESET_8PIN = 8'h04;
   localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

   typedef struct packed {
      logic       hit;
      logic       is_ctl;
      logic [1:0] port;
   } gpcfg_dec_type;

   // ==========================================================
   // helpers
   function automatic gpcfg_dec_type gpcfg_decode(input logic [ADDR_W-1:0] addr);
      logic [11:0]   off;
      gpcfg_dec_type d;
      off      = addr[ADDR_W-1:2] - ADDR_REG_IDX_BASE;
      d.port   = off[3:2];
      d.is_ctl = (off[1:0] == KIND_CTL);
      d.hit    = (addr[1:0] == WORD_ALIGNED) && (off < MAP_SPAN) &&
                 ((off[1:0] == KIND_ADDR) || (off[1:0] == KIND_CTL));
      return d;
   endfunction

   function automatic logic gpcfg_sel_valid(input logic [7:0] sel);
      return (sel >= SEL_FIRST) && (sel <= SEL_LAST);
   endfunction

   // byte of the selected sub-register, zero when nothing is selected
   function automatic logic [7:0] gpcfg_pick(input logic [SUBS_W-1:0] subs, input logic [7:0] sel);
      logic [2:0] lane;
      lane = 3'(sel - SEL_FIRST);
      return gpcfg_sel_valid(sel) ? subs[lane*PINS +: PINS] : SUB_RESET;
   endfunction

   // all-ones over the selected lane, zero when nothing is selected
   function automatic logic [SUBS_W-1:0] gpcfg_lane_mask(input logic [7:0] sel);
      logic [SUBS_W-1:0] m;
      logic [2:0]        lane;
      m    = '0;
      lane = 3'(sel - SEL_FIRST);
      if (gpcfg_sel_valid(sel)) begin
         m[lane*PINS +: PINS] = '1;
      end
      return m;
   endfunction

endpackage

// File: design/gpcfg_port.sv
// gpcfg_port: one port's select register and its bank of configuration sub-registers
module gpcfg_port
   import gpcfg_pkg::*;
#(
   parameter logic [7:0] AFS2_RST = AFS2_RESET
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              sel_wr_in,
   input  wire logic              ctl_wr_in,
   input  wire logic [7:0]        wdata_in,
   output logic      [7:0]        sel_out,
   output logic      [7:0]        ctl_rdata_out,
   output logic      [SUBS_W-1:0] subs_out,
   output logic      [PINS-1:0]   alt_active_out,
   output logic      [2*PINS-1:0] alt_code_out
);

   logic [7:0]  sel_q;
   logic [7:0]  sel_d;
   logic [7:0]  sub_q [SUB_COUNT];
   logic [7:0]  sub_d [SUB_COUNT];
   logic [2:0]  lane;

   // ==========================================================
   // next state: select register and the one selected sub-register
   always_comb begin
      sel_d = sel_q;
      sub_d = sub_q;
      lane  = 3'(sel_q - SEL_FIRST);
      if (sel_wr_in) begin
         sel_d = wdata_in;
      end
      // codes outside one..eight leave the bank alone
      if (ctl_wr_in && gpcfg_sel_valid(sel_q)) begin
         sub_d[lane] = wdata_in;
      end
   end

   // ==========================================================
   // state registers; set two has a package dependent reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_q <= SEL_RESET;
         for (int i = 0; i < SUB_COUNT; i++) begin
            sub_q[i] <= (i == SUB_AFS2) ? AFS2_RST : SUB_RESET;
         end
      end else begin
         sel_q <= sel_d;
         sub_q <= sub_d;
      end
   end

   // ==========================================================
   // flatten the bank for readback and pin control
   always_comb begin
      for (int i = 0; i < SUB_COUNT; i++) begin
         subs_out[i*PINS +: PINS] = sub_q[i];
      end
   end

   assign sel_out       = sel_q;
   assign ctl_rdata_out = gpcfg_pick(subs_out, sel_q);

   // ==========================================================
   // a pin only follows the set bits while its enable bit is on
   always_comb begin
      for (int b = 0; b < PINS; b++) begin
         alt_active_out[b]       = sub_q[SUB_AFEN][b];
         alt_code_out[2*b +: 2]  = sub_q[SUB_AFEN][b] ?
                                   {sub_q[SUB_AFS2][b], sub_q[SUB_AFS1][b]} : 2'b00;
      end
   end

endmodule

// File: test/tb.sv
// tb: self-checking bench for the indirect port configuration block over apb
module tb
   import gpcfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // signals
   logic              mclk;
   logic              reset_n;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [31:0]       cfg_o [SUB_COUNT];
   logic [31:0]       act_o;
   logic [63:0]       code_o;
   logic [7:0]        mdl [NUM_PORTS][SUB_COUNT];
   int                num_errors;
   int                samples_checked;
   int                cycles;
   logic [31:0]       afs2_eight;

   // select codes that reach nothing, and addresses outside the map
   localparam logic [7:0]  UNUSED_CODES [3] = '{SEL_NONE, 8'h09, 8'hff};
   localparam logic [13:0] SEL0_ADDR        = {ADDR_REG_IDX_BASE, 2'b00};
   localparam logic [13:0] BAD_ADDR [4]     = '{SEL0_ADDR + 14'h0008, SEL0_ADDR + 14'h0001,
                                                SEL0_ADDR + 14'h0040, 14'h0000};

   gpcfg_top gpcfg_top_inst (
      .MCLK_IN                            (mclk),
      .RESET_N_IN                         (reset_n),
      .PSEL_IN                            (psel),
      .PENABLE_IN                         (penable),
      .PWRITE_IN                          (pwrite),
      .PADDR_IN                           (paddr),
      .PWDATA_IN                          (pwdata),
      .PSTRB_IN                           (pstrb),
      .PRDATA_OUT                         (prdata),
      .PREADY_OUT                         (pready),
      .PSLVERR_OUT                        (pslverr),
      .PORT_DIR_OUT                       (cfg_o[SUB_DIR]),
      .PORT_ALT_EN_OUT                    (cfg_o[SUB_AFEN]),
      .PORT_OPEN_DRAIN_OUT                (cfg_o[SUB_OD]),
      .PORT_HIGH_DRIVE_OUT                (cfg_o[SUB_HDRV]),
      .PORT_STOP_WAKE_OUT                 (cfg_o[SUB_SWAKE]),
      .PORT_PULLUP_OUT                    (cfg_o[SUB_PULL]),
      .PORT_ALT_FUNCTION_SET_ONE_BITS_OUT (cfg_o[SUB_AFS1]),
      .PORT_ALT_FUNCTION_SET_TWO_BITS_OUT (cfg_o[SUB_AFS2]),
      .PIN_ALT_ACTIVE_OUT                 (act_o),
      .PIN_ALT_CODE_OUT                   (code_o)
   );

   // second copy built as the eight-pin part; only its set two reset differs
   if (1) begin : g_eight_pin
      gpcfg_top #(
         .EIGHT_PIN_VARIANT                  (1'b1)
      ) gpcfg_top_inst (
         .MCLK_IN                            (mclk),
         .RESET_N_IN                         (reset_n),
         .PSEL_IN                            (psel),
         .PENABLE_IN                         (penable),
         .PWRITE_IN                          (pwrite),
         .PADDR_IN                           (paddr),
         .PWDATA_IN                          (pwdata),
         .PSTRB_IN                           (pstrb),
         .PRDATA_OUT                         (),
         .PREADY_OUT                         (),
         .PSLVERR_OUT                        (),
         .PORT_DIR_OUT                       (),
         .PORT_ALT_EN_OUT                    (),
         .PORT_OPEN_DRAIN_OUT                (),
         .PORT_HIGH_DRIVE_OUT                (),
         .PORT_STOP_WAKE_OUT                 (),
         .PORT_PULLUP_OUT                    (),
         .PORT_ALT_FUNCTION_SET_ONE_BITS_OUT (),
         .PORT_ALT_FUNCTION_SET_TWO_BITS_OUT (afs2_eight),
         .PIN_ALT_ACTIVE_OUT                 (),
         .PIN_ALT_CODE_OUT                   ()
      );
   end

   // ==========================================================
   // clock and hang guard, ceiling far above the few hundred cycles used
   always #2 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   // ==========================================================
   // compare and closing tasks
   task automatic cmp_data(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // apb master: called at a rising edge, leaves psel up so transfers run back to back
   task automatic apb_xfer(input logic wr, input logic [13:0] addr, input logic [31:0] data,
                           input logic [3:0] strb, output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      pstrb   <= strb;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // no wait limit here: the cycle ceiling above ends a hang
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd  = prdata;
      err = pslverr;
   endtask

   task automatic idle();
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [13:0] addr, input logic [7:0] data, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb_xfer(1'b1, addr, {24'hffffff, data}, 4'hf, rd, err);
      cmp_flag("write error", exp_err, err);
   endtask

   task automatic rd_chk(input string what, input logic [13:0] addr, input logic [7:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb_xfer(1'b0, addr, 32'h0, 4'h0, rd, err);
      cmp_data(what, {56'h0, exp}, {32'h0, rd});
      cmp_flag(what, exp_err, err);
   endtask

   function automatic logic [13:0] sel_addr(input int p);
      return {ADDR_REG_IDX_BASE, 2'b00} + 14'(16 * p);
   endfunction

   function automatic logic [13:0] ctl_addr(input int p);
      return sel_addr(p) + 14'h004;
   endfunction

   // pin outputs against the model, sampled mid-cycle when settled
   task automatic chk_pins(input string tname);
      logic [31:0] e;
      logic [31:0] a;
      logic [63:0] c;
      @(negedge mclk);
      for (int s = 0; s < SUB_COUNT; s++) begin
         for (int p = 0; p < NUM_PORTS; p++) e[8*p +: 8] = mdl[p][s];
         cmp_data($sformatf("%s lane %0d", tname, s), {32'h0, e}, {32'h0, cfg_o[s]});
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         a[8*p +: 8] = mdl[p][SUB_AFEN];
         for (int b = 0; b < PINS; b++) begin
            c[16*p+2*b +: 2] = mdl[p][SUB_AFEN][b] ? {mdl[p][SUB_AFS2][b], mdl[p][SUB_AFS1][b]} : 2'b00;
         end
      end
      cmp_data({tname, " alt active"}, {32'h0, a}, {32'h0, act_o});
      cmp_data({tname, " alt code"}, c, code_o);
      @(posedge mclk);
   endtask

   task automatic mdl_reset();
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int s = 0; s < SUB_COUNT; s++) mdl[p][s] = (s == SUB_AFS2) ? AFS2_RESET : SUB_RESET;
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] rd;
      logic        err;
      logic [7:0]  v;
      mclk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = '0; pwdata = '0; pstrb = '0;
      num_errors = 0; samples_checked = 0; cycles = 0;
      mdl_reset();
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);

      // reset state, and control accesses with nothing selected
      chk_pins("reset");
      cmp_data("eight pin set two", {32'h0, AFS2_RESET, AFS2_RESET, AFS2_RESET, AFS2_RESET_8PIN}, {32'h0, afs2_eight});
      cmp_flag("ready", 1'b1, pready);
      for (int p = 0; p < NUM_PORTS; p++) begin
         rd_chk("select reset", sel_addr(p), SEL_RESET, 1'b0);
         wr(ctl_addr(p), 8'hff, 1'b0);
         rd_chk("ctl none", ctl_addr(p), 8'h00, 1'b0);
      end
      idle();
      chk_pins("guard");
      $display("test reset done");

      // every code one to eight on every port, distinct values so a wrong lane shows up
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int s = 0; s < SUB_COUNT; s++) begin
            v = 8'(8'h5a ^ (p * 37 + s * 83));
            mdl[p][s] = v;
            wr(sel_addr(p), 8'(s + 1), 1'b0);
            wr(ctl_addr(p), v, 1'b0);
         end
      end
      idle();
      chk_pins("codes");
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int s = SUB_COUNT - 1; s >= 0; s--) begin
            wr(sel_addr(p), 8'(s + 1), 1'b0);
            rd_chk("ctl readback", ctl_addr(p), mdl[p][s], 1'b0);
         end
      end
      idle();
      $display("test codes done");

      // unused select codes keep their value but reach nothing
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int i = 0; i < 3; i++) begin
            v = UNUSED_CODES[i];
            wr(sel_addr(p), v, 1'b0);
            rd_chk("select value", sel_addr(p), v, 1'b0);
            wr(ctl_addr(p), 8'ha5, 1'b0);
            rd_chk("ctl unused", ctl_addr(p), 8'h00, 1'b0);
         end
      end
      idle();
      chk_pins("unused");
      $display("test unused done");

      // strobe low write and unmapped places change nothing
      wr(sel_addr(1), SEL_AFEN, 1'b0);
      apb_xfer(1'b1, ctl_addr(1), 32'h0000_00ff ^ 32'(mdl[1][SUB_AFEN]), 4'he, rd, err);
      rd_chk("strobe", ctl_addr(1), mdl[1][SUB_AFEN], 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(BAD_ADDR[i], 8'h08, 1'b1);
         rd_chk("unmapped", sel_addr(0) + 14'h0008, 8'h00, 1'b1);
      end
      rd_chk("select kept", sel_addr(0), 8'hff, 1'b0);
      idle();
      chk_pins("refused");
      $display("test refused done");

      // second reset in mid-run
      reset_n <= 1'b0;
      @(posedge mclk);
      reset_n <= 1'b1;
      mdl_reset();
      @(posedge mclk);
      chk_pins("rereset");
      cmp_data("eight pin rereset", {32'h0, AFS2_RESET, AFS2_RESET, AFS2_RESET, AFS2_RESET_8PIN}, {32'h0, afs2_eight});
      rd_chk("select rereset", sel_addr(3), SEL_RESET, 1'b0);
      idle();
      $display("test rereset done");
      end_sim();
   end

endmodule
